// ---- common/evc_link_if.sv ----
// Signals between the controller and its filter and clock output modules.
// Assumes one clock domain shared by all three modules.
`timescale 1ns/1ps
`default_nettype none
interface evc_link_if;
    logic raw;
    logic sample_tick;
    logic filter_en;
    evc_pkg::evc_edge_type polarity;
    logic count_edge;
    logic level_sync;
    logic level_filt;
    logic [3:0] underflow;
    logic [1:0] chan_sel;
    logic out_en;
    logic toggle_lvl;
    logic pin;
    modport nf (input raw, input sample_tick, input filter_en, input polarity,
        output count_edge, output level_sync, output level_filt);
    modport co (input underflow, input chan_sel, input out_en,
        output toggle_lvl, output pin);
    modport ctl (output raw, output sample_tick, output filter_en, output polarity,
        input count_edge, input level_sync, input level_filt,
        output underflow, output chan_sel, output out_en,
        input toggle_lvl, input pin);
endinterface : evc_link_if
`default_nettype wire

// ---- common/evc_map.svh ----
// Register indices, field positions, reset values and divider masks of the
// event counter and clock output block.
// Assumes APB byte address = 4 * register index.
`ifndef EVC_MAP_SVH
`define EVC_MAP_SVH

`define EVC_ADDR_W 18
`define EVC_IDX_WIDTH_SEL 16'hFFC0
`define EVC_IDX_EVENT_CFG 16'hFFC1
`define EVC_IDX_CLKOUT_CTL 16'hFFC2
`define EVC_IDX_STATUS 16'hFFCF

`define EVC_BIT_PAIR01 0
`define EVC_BIT_PAIR23 1
`define EVC_BIT_POLARITY 0
`define EVC_BIT_FILTER 1
`define EVC_BIT_COUNTER_MODE_SELECT 2
`define EVC_BIT_OUTEN 2
`define EVC_FLD_OUTPUT_CHANNEL_SELECT 1:0

`define EVC_RST_WIDTH_SEL 2'h0
`define EVC_RST_EVENT_CFG 3'h0
`define EVC_RST_CLKOUT_CTL 3'h0
`define EVC_RST_PIN_LEVEL 1'h1
`define EVC_RST_TOGGLE 1'h0

`define EVC_PRE_W 8
`define EVC_PRE_DIV4 8'h03
`define EVC_PRE_DIV32 8'h1F
`define EVC_PRE_DIV256 8'hFF

`endif

// ---- common/evc_pkg.sv ----
// Shared types of the event counter and clock output block.
// Assumes nothing of its surroundings.
package evc_pkg;
    typedef enum logic [1:0] {
        EVC_RATIO_DIV1 = 2'b00,
        EVC_RATIO_DIV4 = 2'b01,
        EVC_RATIO_DIV32 = 2'b10,
        EVC_RATIO_DIV256 = 2'b11
    } evc_ratio_type;
    typedef enum logic {
        EVC_EDGE_FALL = 1'b0,
        EVC_EDGE_RISE = 1'b1
    } evc_edge_type;
endpackage : evc_pkg

// ---- dv/evc_partner.sv ----
// External pulse source on the event pin and clocked device on the port.
// Assumes the bench calls its tasks; the event pin idles high.
`timescale 1ns/1ps
`default_nettype none
module evc_partner (
    input wire logic mclk_in,
    input wire logic clk_port_in,
    output logic pin_out,
    output int rises_out
);
    // ----------------------------------------
    // Clocked device: counts rising edges
    // ----------------------------------------
    logic last_q;
    initial
    begin
        pin_out = 1'b1;
        rises_out = 0;
        last_q = 1'b1;
    end
    always @(posedge mclk_in)
    begin
        last_q <= clk_port_in;
        if (clk_port_in === 1'b1 && last_q === 1'b0)
            rises_out <= rises_out + 1;
    end
    // ----------------------------------------
    // Pulse source
    // ----------------------------------------
    task automatic hold(input logic v, input int w);
        @(posedge mclk_in);
        pin_out <= v;
        repeat (w) @(posedge mclk_in);
    endtask : hold
    // Each phase lasts w + 1 cycles, longer than two sample periods when filtered
    task automatic pulses(input int n, input int w);
        repeat (n)
        begin
            hold(1'b0, w);
            hold(1'b1, w);
        end
    endtask : pulses
endmodule : evc_partner
`default_nettype wire

// ---- dv/tb_top.sv ----
// Self-checking bench of the event counter and clock output block.
// Assumes the partner model drives the event pin; APB slave never waits.
`timescale 1ns/1ps
`default_nettype none
`include "evc_map.svh"
module tb_top;
    localparam logic [17:0] addr_ws = {`EVC_IDX_WIDTH_SEL, 2'b00};
    localparam logic [17:0] addr_ev = {`EVC_IDX_EVENT_CFG, 2'b00};
    localparam logic [17:0] addr_co = {`EVC_IDX_CLKOUT_CTL, 2'b00};
    localparam logic [17:0] addr_st = {`EVC_IDX_STATUS, 2'b00};
    localparam logic [17:0] addr_bad = 18'h3FF10;
    logic mclk_in, reset_in, psel, penable, pwrite, pready, pslverr;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic pin, port, cnt0, ch1, ch3, w01, w23, e, tg;
    logic [1:0] ratio;
    logic [2:0] presc;
    logic [3:0] ufl;
    int miscompares = 0;
    int check_count = 0;
    int c0 = 0;
    int c1 = 0;
    int c3 = 0;
    int rises, s, ch;
    evc_top #(.PRESCALER_SETTING_W(3)) uut (
        .mclk_in(mclk_in), .reset_in(reset_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .event_input_pin_in(pin),
        .clock_output_port_out(port), .timer0_division_ratio_in(ratio),
        .prescaler_setting_in(presc), .underflow_in(ufl),
        .timer0_count_out(cnt0), .timer1_chain_out(ch1),
        .timer3_chain_out(ch3), .pair01_width_select_out(w01),
        .pair23_width_select_out(w23)
    );
    evc_partner part (
        .mclk_in(mclk_in), .clk_port_in(port), .pin_out(pin),
        .rises_out(rises)
    );
    always @(posedge mclk_in)
    begin
        if (cnt0 === 1'b1)
            c0 <= c0 + 1;
        if (ch1 === 1'b1)
            c1 <= c1 + 1;
        if (ch3 === 1'b1)
            c3 <= c3 + 1;
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : finish_test
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        check_count++;
        if (g !== x)
        begin
            $display("wrong value %s expected %h seen %h", nm, x, g);
            miscompares++;
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_in);
    endtask : cyc
    task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d,
        output logic [31:0] rd, output logic er);
        int i;
        @(posedge mclk_in);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk_in);
        penable <= 1'b1;
        for (i = 0; i < 20; i++)
        begin
            @(posedge mclk_in);
            if (pready === 1'b1)
                break;
        end
        if (i == 20)
        begin
            miscompares++;
            finish_test();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [17:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic y;
        apb(1'b1, a, d, q, y);
    endtask : wr
    task automatic rdc(input string nm, input logic [17:0] a, input logic [31:0] x);
        logic [31:0] q;
        logic y;
        apb(1'b0, a, 32'h0, q, y);
        chk(nm, x, q);
        chk("read slverr", 0, y);
    endtask : rdc
    task automatic uf(input logic [3:0] m);
        @(posedge mclk_in);
        ufl <= m;
        @(posedge mclk_in);
        ufl <= 4'h0;
        cyc(2);
    endtask : uf
    // ----------------------------------------
    // Clock, reset and scenarios
    // ----------------------------------------
    initial
    begin
        mclk_in = 1'b0;
        forever #20 mclk_in = ~mclk_in;
    end
    initial
    begin
        reset_in = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 18'h0;
        pwdata = 32'h0;
        ratio = 2'h0;
        presc = 3'h0;
        ufl = 4'h0;
        cyc(10);
        reset_in <= 1'b0;
        chk("port reset", 1, port);
        rdc("width reset", addr_ws, 0);
        rdc("event reset", addr_ev, 0);
        rdc("clkout reset", addr_co, 0);
        rdc("status idle", addr_st, 32'h3);
        wr(addr_ev, 32'hF);
        rdc("event top bit", addr_ev, 32'h7);
        wr(addr_ev, 32'h0);
        apb(1'b0, addr_bad, 32'h0, r, e);
        chk("unmapped err", 1, e);
        chk("unmapped data", 0, r);
        for (int k = 0; k < 4; k++)
        begin
            ratio <= 2'(k);
            cyc(300);
            s = c0;
            cyc(1024);
            chk("timer ticks", s + (1024 >> (k == 0 ? 0 : k == 1 ? 2 : k == 2 ? 5 : 8)), c0);
        end
        wr(addr_ev, 32'h4);
        cyc(8);
        s = c0;
        cyc(1024);
        chk("ratio ignored", s, c0);
        part.pulses(5, 8);
        cyc(8);
        chk("event count", s + 5, c0);
        for (int p = 0; p < 2; p++)
        begin
            wr(addr_ev, 32'h4 | p);
            cyc(8);
            s = c0;
            part.hold(1'b0, 10);
            chk("fall edge", s + (p == 0 ? 1 : 0), c0);
            part.hold(1'b1, 10);
            chk("rise edge", s + 1, c0);
        end
        wr(addr_ev, 32'h6);
        part.hold(1'b1, 600);
        s = c0;
        part.hold(1'b0, 100);
        part.hold(1'b1, 1200);
        chk("glitch dropped", s, c0);
        part.hold(1'b0, 520);
        part.hold(1'b1, 1200);
        chk("n1 passed", s + 1, c0);
        presc <= 3'h1;
        part.hold(1'b1, 1200);
        s = c0;
        part.hold(1'b0, 510);
        part.hold(1'b1, 1600);
        chk("n2 dropped", s, c0);
        part.pulses(2, 1100);
        part.hold(1'b1, 1200);
        chk("filtered count", s + 2, c0);
        tg = 1'b0;
        wr(addr_co, 32'h4);
        cyc(3);
        chk("pin start", 0, port);
        for (ch = 0; ch < 4; ch++)
        begin
            wr(addr_co, 32'h4 | ch);
            uf(4'(4'h1 << ((ch + 1) % 4)));
            chk("pin other", tg, port);
            uf(4'(4'h1 << ch));
            tg = ~tg;
            chk("pin flip", tg, port);
        end
        chk("port rises", 2, rises);
        wr(addr_co, 32'h0);
        cyc(3);
        chk("pin off", 1, port);
        wr(addr_ws, 32'hF);
        rdc("width rw", addr_ws, 32'h3);
        chk("pair01 out", 1, w01);
        chk("pair23 out", 1, w23);
        wr(addr_co, 32'h5);
        cyc(2);
        chk("pin 16bit low", 0, port);
        uf(4'h2);
        chk("pin 16bit", 1, port);
        s = c1;
        uf(4'h1);
        chk("chain01", s + 1, c1);
        s = c3;
        uf(4'h4);
        chk("chain23", s + 1, c3);
        wr(addr_ws, 32'h0);
        s = c1;
        uf(4'h1);
        chk("no chain 8bit", s, c1);
        finish_test();
    end
endmodule : tb_top
`default_nettype wire

// ---- rtl/evc_clkout.sv ----
// Underflow channel selector, halving toggle and output pin gate.
// Assumes underflow strobes are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
`include "evc_map.svh"
module evc_clkout (
    input wire logic mclk_in,
    input wire logic reset_in,
    evc_link_if.co lnk
);
    logic tgl_q, tgl_d, pin_q, pin_d, sel_uf;

    always_comb
    begin
        sel_uf = lnk.underflow[lnk.chan_sel];
        tgl_d = sel_uf ? ~tgl_q : tgl_q;
        pin_d = lnk.out_en ? tgl_d : 1'b1;
    end

    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            tgl_q <= `EVC_RST_TOGGLE;
            pin_q <= `EVC_RST_PIN_LEVEL;
        end
        else
        begin
            tgl_q <= tgl_d;
            pin_q <= pin_d;
        end
    end

    assign lnk.toggle_lvl = tgl_q;
    assign lnk.pin = pin_q;

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (reset_in);

    a_toggle_on_uf: assert property (lnk.underflow[lnk.chan_sel] |=> tgl_q != $past(tgl_q))
        else $error("toggle missed a selected underflow");
    a_chan_ignore: assert property (!lnk.underflow[lnk.chan_sel] |=> $stable(tgl_q))
        else $error("toggle moved without selected underflow");
    a_pin_high_off: assert property (!lnk.out_en |=> pin_q)
        else $error("pin not high while output disabled");
    a_pin_follows: assert property (lnk.out_en |=> pin_q == tgl_q)
        else $error("pin does not follow toggle");
endmodule : evc_clkout
`default_nettype wire

// ---- rtl/evc_noise_filter.sv ----
// Event input synchroniser, noise rejector and edge selector.
// Assumes the sample tick is a one-cycle pulse of the system clock.
`timescale 1ns/1ps
`default_nettype none
`include "evc_map.svh"
module evc_noise_filter (
    input wire logic mclk_in,
    input wire logic reset_in,
    evc_link_if.nf lnk
);
    logic sync1_q, sync2_q, samp_q, filt_q, prev_q;
    logic samp_d, filt_d, prev_d, level;

    always_comb
    begin
        samp_d = samp_q;
        filt_d = filt_q;
        if (lnk.sample_tick)
        begin
            samp_d = sync2_q;
            if (samp_q == sync2_q)
                filt_d = sync2_q;
        end
        level = lnk.filter_en ? filt_q : sync2_q;
        prev_d = level;
    end

    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            sync1_q <= `EVC_RST_PIN_LEVEL;
            sync2_q <= `EVC_RST_PIN_LEVEL;
            samp_q <= `EVC_RST_PIN_LEVEL;
            filt_q <= `EVC_RST_PIN_LEVEL;
            prev_q <= `EVC_RST_PIN_LEVEL;
        end
        else
        begin
            sync1_q <= lnk.raw;
            sync2_q <= sync1_q;
            samp_q <= samp_d;
            filt_q <= filt_d;
            prev_q <= prev_d;
        end
    end

    assign lnk.count_edge = (lnk.polarity == evc_pkg::EVC_EDGE_RISE) ?
        (level & ~prev_q) : (~level & prev_q);
    assign lnk.level_sync = sync2_q;
    assign lnk.level_filt = filt_q;

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (reset_in);

    a_sync_two_stage: assert property (##2 sync2_q == $past(lnk.raw, 2))
        else $error("event input not delayed by two stages");
    a_filter_needs_two: assert property (lnk.sample_tick && samp_q != sync2_q
        |=> filt_q == $past(filt_q))
        else $error("filter passed a level after one sample");
    a_edge_polarity: assert property (lnk.count_edge |-> level == lnk.polarity)
        else $error("count edge of wrong polarity");
endmodule : evc_noise_filter
`default_nettype wire

// ---- rtl/evc_top.sv ----
// Event counter input and divided underflow clock output, with APB registers.
// Assumes a timer core that counts on timer0_count_out and reports
// underflows as one-cycle pulses on underflow_in.
// Assumes software keeps the shared port pin a plain driven output.
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "evc_map.svh"

// Summary of operation
// - Mode bit makes event pin clock timer 0
// - Paired 0/1 form 16-bit event counter
// - Division ratio ignored in event mode
// - Polarity 0 falling edge, 1 rising
// - Filter bit enables noise rejector
// - Sample clock is fosc over 256 times n
// - Level passes at second sample edge
// - Event mode changes only clock source
// - Output toggles on each selected underflow
// - Channel field picks timer 0 to 3
// - Output enabled drives clock, else high
// - Enable gating unsynchronised, half cycle glitch; here pin_q registers the gated level on mclk_in
// - Width bits select 16-bit, reset 0
// - Mode, filter, polarity reset 0; top bit 0
// - Low underflow clocks high timer in 16-bit
module evc_top #(
    parameter int PRESCALER_SETTING_W = 3
) (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [`EVC_ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic event_input_pin_in,
    output logic clock_output_port_out,
    input wire logic [1:0] timer0_division_ratio_in,
    input wire logic [PRESCALER_SETTING_W-1:0] prescaler_setting_in,
    input wire logic [3:0] underflow_in,
    output logic timer0_count_out,
    output logic timer1_chain_out,
    output logic timer3_chain_out,
    output logic pair01_width_select_out,
    output logic pair23_width_select_out
);
    if (PRESCALER_SETTING_W < 1 || PRESCALER_SETTING_W > 8)
    begin : g_bad_prescaler_setting
        $error("PRESCALER_SETTING_W must lie between 1 and 8");
    end

    evc_link_if lnk ();

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [1:0] width_q, width_d;
    logic [2:0] evcfg_q, evcfg_d;
    logic [2:0] clkctl_q, clkctl_d;
    logic [31:0] rdata_q, rdata_d;

    logic counter_mode_select;
    logic filter_select;
    logic edge_polarity_select;
    logic divided_clock_output;
    logic [1:0] output_channel_select;
    logic pair01_width_select;
    logic pair23_width_select;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    logic [15:0] idx;
    logic aligned;
    logic hit;
    logic setup;
    logic wr_en;
    logic [31:0] rd_mux;

    // Misaligned and unmapped accesses read zero and answer with pslverr
    assign idx = paddr_in[`EVC_ADDR_W-1:2];
    assign aligned = (paddr_in[1:0] == 2'h0);
    assign setup = psel_in & ~penable_in;

    always_comb
    begin
        hit = 1'b0;
        rd_mux = 32'h0000_0000;
        if (aligned)
        begin
            unique case (idx)
                `EVC_IDX_WIDTH_SEL:
                begin
                    hit = 1'b1;
                    rd_mux = {30'h0000_0000, width_q};
                end
                `EVC_IDX_EVENT_CFG:
                begin
                    hit = 1'b1;
                    rd_mux = {29'h0000_0000, evcfg_q};
                end
                `EVC_IDX_CLKOUT_CTL:
                begin
                    hit = 1'b1;
                    rd_mux = {29'h0000_0000, clkctl_q};
                end
                `EVC_IDX_STATUS:
                begin
                    hit = 1'b1;
                    rd_mux = {29'h0000_0000, lnk.toggle_lvl, lnk.level_filt,
                        lnk.level_sync};
                end
                default:
                begin
                    hit = 1'b0;
                    rd_mux = 32'h0000_0000;
                end
            endcase
        end
    end

    // Read data is captured in the setup cycle so the access phase needs no wait
    assign pready_out = 1'b1;
    assign pslverr_out = psel_in & penable_in & ~hit;
    assign wr_en = psel_in & penable_in & pwrite_in & hit;
    assign prdata_out = rdata_q;

    always_comb
    begin
        width_d = width_q;
        evcfg_d = evcfg_q;
        clkctl_d = clkctl_q;
        rdata_d = rdata_q;
        if (setup)
            rdata_d = pwrite_in ? 32'h0000_0000 : rd_mux;
        if (wr_en)
        begin
            unique case (idx)
                `EVC_IDX_WIDTH_SEL: width_d = pwdata_in[1:0];
                `EVC_IDX_EVENT_CFG: evcfg_d = pwdata_in[2:0];
                `EVC_IDX_CLKOUT_CTL: clkctl_d = pwdata_in[2:0];
                default: width_d = width_q;
            endcase
        end
    end

    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            width_q <= `EVC_RST_WIDTH_SEL;
            evcfg_q <= `EVC_RST_EVENT_CFG;
            clkctl_q <= `EVC_RST_CLKOUT_CTL;
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            width_q <= width_d;
            evcfg_q <= evcfg_d;
            clkctl_q <= clkctl_d;
            rdata_q <= rdata_d;
        end
    end

    assign counter_mode_select = evcfg_q[`EVC_BIT_COUNTER_MODE_SELECT];
    assign filter_select = evcfg_q[`EVC_BIT_FILTER];
    assign edge_polarity_select = evcfg_q[`EVC_BIT_POLARITY];
    assign divided_clock_output = clkctl_q[`EVC_BIT_OUTEN];
    assign output_channel_select = clkctl_q[`EVC_FLD_OUTPUT_CHANNEL_SELECT];
    assign pair01_width_select = width_q[`EVC_BIT_PAIR01];
    assign pair23_width_select = width_q[`EVC_BIT_PAIR23];
    assign pair01_width_select_out = pair01_width_select;
    assign pair23_width_select_out = pair23_width_select;

    // ------------------------------------------------------------
    // Prescaler and noise sample divider
    // ------------------------------------------------------------
    logic [`EVC_PRE_W-1:0] pre_q, pre_d;
    logic [PRESCALER_SETTING_W-1:0] nr_q, nr_d;
    logic tick4, tick32, tick256, tick_nr;

    // Free-running from reset; its low bits give the ratio ticks
    assign tick4 = ((pre_q & `EVC_PRE_DIV4) == `EVC_PRE_DIV4);
    assign tick32 = ((pre_q & `EVC_PRE_DIV32) == `EVC_PRE_DIV32);
    assign tick256 = (pre_q == `EVC_PRE_DIV256);
    // One sample per n periods of fosc/256, n = setting + 1
    assign tick_nr = tick256 && (nr_q >= prescaler_setting_in);

    always_comb
    begin
        pre_d = pre_q + `EVC_PRE_W'(1);
        nr_d = nr_q;
        if (tick256)
            nr_d = tick_nr ? '0 : nr_q + PRESCALER_SETTING_W'(1);
    end

    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            pre_q <= '0;
            nr_q <= '0;
        end
        else
        begin
            pre_q <= pre_d;
            nr_q <= nr_d;
        end
    end

    // ------------------------------------------------------------
    // Timer clock selection
    // ------------------------------------------------------------
    logic div_tick;
    logic t0_cnt_q, t0_cnt_d;
    logic t1_chain_q, t1_chain_d;
    logic t3_chain_q, t3_chain_d;

    always_comb
    begin
        unique case (evc_pkg::evc_ratio_type'(timer0_division_ratio_in))
            evc_pkg::EVC_RATIO_DIV1: div_tick = 1'b1;
            evc_pkg::EVC_RATIO_DIV4: div_tick = tick4;
            evc_pkg::EVC_RATIO_DIV32: div_tick = tick32;
            evc_pkg::EVC_RATIO_DIV256: div_tick = tick256;
        endcase
        // Same count input of the core either way, only its source differs
        t0_cnt_d = counter_mode_select ? lnk.count_edge : div_tick;
        // Pair 0/1 chains timer 1 from timer 0, so events reach 16 bits
        t1_chain_d = pair01_width_select & underflow_in[0];
        // Timer 3 only ever sees the pair 2/3 chain, never event edges
        t3_chain_d = pair23_width_select & underflow_in[2];
    end

    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            t0_cnt_q <= 1'b0;
            t1_chain_q <= 1'b0;
            t3_chain_q <= 1'b0;
        end
        else
        begin
            t0_cnt_q <= t0_cnt_d;
            t1_chain_q <= t1_chain_d;
            t3_chain_q <= t3_chain_d;
        end
    end

    assign timer0_count_out = t0_cnt_q;
    assign timer1_chain_out = t1_chain_q;
    assign timer3_chain_out = t3_chain_q;

    // ------------------------------------------------------------
    // Filter and clock output
    // ------------------------------------------------------------
    assign lnk.raw = event_input_pin_in;
    assign lnk.sample_tick = tick_nr;
    assign lnk.filter_en = filter_select;
    assign lnk.polarity = evc_pkg::evc_edge_type'(edge_polarity_select);
    assign lnk.underflow = underflow_in;
    assign lnk.chan_sel = output_channel_select;
    assign lnk.out_en = divided_clock_output;
    assign clock_output_port_out = lnk.pin;

    evc_noise_filter u_filter (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .lnk(lnk.nf)
    );

    evc_clkout u_clkout (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .lnk(lnk.co)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (reset_in);

    sequence s_cfg_write;
        wr_en && idx == `EVC_IDX_EVENT_CFG;
    endsequence

    sequence s_event_edge;
        counter_mode_select && lnk.count_edge;
    endsequence

    // Writes land at the access edge and read back one edge later
    sequence s_clk_write;
        wr_en && idx == `EVC_IDX_CLKOUT_CTL;
    endsequence

    sequence s_pair23_uf;
        pair23_width_select && underflow_in[2];
    endsequence

    a_event_clock_src: assert property (s_event_edge |=> timer0_count_out)
        else $error("event edge did not clock timer 0");
    a_ratio_ignored: assert property (counter_mode_select && !lnk.count_edge
        |=> !timer0_count_out)
        else $error("divided clock reached timer 0 in event mode");
    a_timer_ratio: assert property (!counter_mode_select && div_tick
        |=> timer0_count_out)
        else $error("divided clock lost in timer mode");
    a_chain_pair01: assert property (pair01_width_select && underflow_in[0]
        |=> timer1_chain_out)
        else $error("timer 0 underflow did not clock timer 1");
    a_chain_off: assert property (!pair01_width_select |=> !timer1_chain_out)
        else $error("timer 1 chained while in 8-bit mode");
    a_nr_tick_rate: assert property (tick_nr |-> tick256 && pre_q == `EVC_PRE_DIV256)
        else $error("noise sample tick off the fosc/256 grid");
    a_cfg_write: assert property (s_cfg_write |=> evcfg_q == $past(pwdata_in[2:0]))
        else $error("event config write not stored");
    a_reset_values: assert property ($past(reset_in) |-> width_q == `EVC_RST_WIDTH_SEL
        && evcfg_q == `EVC_RST_EVENT_CFG)
        else $error("config not zero after reset");
    a_chain_pair23: assert property (s_pair23_uf |=> timer3_chain_out)
        else $error("timer 2 underflow did not clock timer 3");
    a_chain23_off: assert property (!pair23_width_select |=> !timer3_chain_out)
        else $error("timer 3 chained while in 8-bit mode");
    a_no_event_23: assert property (!(pair23_width_select && underflow_in[2])
        |=> !timer3_chain_out)
        else $error("timer 3 clocked without a timer 2 underflow");
    a_clk_write: assert property (s_clk_write |=> clkctl_q == $past(pwdata_in[2:0]))
        else $error("clock output control write not stored");
    a_timer_quiet: assert property (!counter_mode_select && !div_tick
        |=> !timer0_count_out)
        else $error("timer 0 clocked without a divided tick");
    a_width_write: assert property (wr_en && idx == `EVC_IDX_WIDTH_SEL
        |=> width_q == $past(pwdata_in[1:0]))
        else $error("width select write not stored");
    a_toggle_reset: assert property ($past(reset_in) |-> !lnk.toggle_lvl)
        else $error("output toggle not zero after reset");
endmodule : evc_top
`default_nettype wire
